/* File: hw/pmtr_top.sv */
// Program memory read port with table pointer, table reads and debug pins.
//
// Functional notes
// (RULE1) Memory holds 16K words of 16 bits, read by PC and table pointer.
// (RULE2) After reset the fetch address starts at zero.
// (RULE3) Table address is high pointer concatenated above low pointer.
// (RULE4) Normal reads serve sector 0; extended reads serve other sectors.
// (RULE5) Low byte of the word goes to the named data register.
// (RULE6) High byte of the word loads the table high byte latch.
// (RULE7) Latch bits without backing word bits read as zero.
// (RULE8) Every table instruction takes exactly two instruction cycles.
// (RULE9) Table high byte latch is readable and writable by software.
// (RULE10) Normal variant takes the address from both pointer registers.
// (RULE11) Last-page variants ignore high pointer and read the last page.
// (RULE12) Software disables interrupts around main-routine table reads.
// (RULE13) Programming port: one two-way data pin, clock from programmer.
// (RULE14) While debugging, shared pin normal functions are disabled.
// (RULE15) Debug data pin is two-way, clock input-only; both serve programming.
// (RULE16) A page is 256 words: low pointer picks word, high picks page.
// (RULE17) High pointer bits above the 16K address are ignored.
`timescale 1ns/100ps
module pmtr_top #(
  parameter int unsigned WORDS  = pmtr_pkg::WORDS,
  parameter int unsigned ADDR_W = pmtr_pkg::ADDR_W
) (
  // Clock and reset.
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // Instruction fetch.
  input  wire logic                 fetch_adv,
  input  wire logic                 fetch_load,
  input  wire logic [ADDR_W-1:0]    fetch_target,
  output logic      [ADDR_W-1:0]    fetch_addr_ff,
  output logic      [15:0]          fetch_word_ff,
  output logic                      fetch_valid_ff,
  // Table pointer and latch access by software.
  input  wire logic                 tblp_wr,
  input  wire logic                 tbhp_wr,
  input  wire logic                 latch_wr,
  input  wire logic [7:0]           sfr_wdata,
  output logic      [7:0]           tblp_ff,
  output logic      [7:0]           tbhp_ff,
  output logic      [7:0]           table_high_byte_latch_ff,
  // Table read request and result.
  input  pmtr_pkg::pmtr_req_t       tbl_req,
  output logic                      tbl_busy_ff,
  output logic                      tbl_illegal_ff,
  output pmtr_pkg::pmtr_wr_t        tbl_wr_ff,
  // Program load path from the serial programming logic.
  input  wire logic                 prog_load_en,
  input  wire logic [ADDR_W-1:0]    prog_load_addr,
  input  wire logic [15:0]          prog_load_data,
  // Shared pins.
  input  wire logic                 debug_en,
  input  wire logic                 debug_serial_data_pin_i,
  input  wire logic                 debug_serial_clock_pin_i,
  input  wire logic                 dbg_data_out,
  input  wire logic                 dbg_data_oe,
  input  wire logic                 gpio_data_out,
  input  wire logic                 gpio_data_oe,
  input  wire logic                 gpio_clk_out,
  input  wire logic                 gpio_clk_oe,
  output logic                      debug_serial_data_pin_o_ff,
  output logic                      debug_serial_data_pin_oe_ff,
  output logic                      debug_serial_clock_pin_o_ff,
  output logic                      debug_serial_clock_pin_oe_ff,
  output logic                      gpio_data_in_ff,
  output logic                      gpio_clk_in_ff,
  output logic                      link_data_in_ff,
  output logic                      link_clk_in_ff
);

  initial
  begin
    if (WORDS != (1 << ADDR_W) || ADDR_W <= pmtr_pkg::PAGE_W)
    begin
      $error("pmtr_top needs a power-of-two memory above one page");
    end
  end

  typedef enum logic [1:0] {
    pmtr_st_idle,
    pmtr_st_wait,
    pmtr_st_done
  } pmtr_state_t;

  // Word address of a table read; last-page reads force the page bits high.
  function automatic logic [ADDR_W-1:0] tbl_addr(
    input pmtr_pkg::pmtr_op_t op,
    input logic [7:0]         hi,
    input logic [7:0]         lo
  );
    logic last;
    last = (op == pmtr_pkg::pmtr_op_rdl) || (op == pmtr_pkg::pmtr_op_ext_rdl);
    if (last)
    begin
      tbl_addr = {{(ADDR_W - pmtr_pkg::PAGE_W){1'b1}}, lo};
    end
    else
    begin
      tbl_addr = {hi[ADDR_W-pmtr_pkg::PAGE_W-1:0], lo};
    end
  endfunction

  function automatic logic is_ext(input pmtr_pkg::pmtr_op_t op);
    is_ext = (op == pmtr_pkg::pmtr_op_ext_rd) ||
             (op == pmtr_pkg::pmtr_op_ext_rdl);
  endfunction

  pmtr_state_t         st_ff;
  pmtr_state_t         nxt_st;
  pmtr_pkg::pmtr_req_t req_ff;
  pmtr_pkg::pmtr_req_t nxt_req;
  pmtr_pkg::pmtr_wr_t  nxt_wr;
  logic [7:0]          nxt_tblp;
  logic [7:0]          nxt_tbhp;
  logic [7:0]          nxt_latch;
  logic                nxt_busy;
  logic                nxt_illegal;
  logic [ADDR_W-1:0]   nxt_fetch;
  logic                nxt_fvalid;
  logic                fetch_pend_ff;
  logic                rd_en;
  logic [ADDR_W-1:0]   rd_addr;
  logic [15:0]         rd_data;
  logic                tbl_start;
  logic                req_legal;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // (RULE1) Shared word store
  pmtr_rom #(
    .DEPTH (WORDS),
    .AW    (ADDR_W),
    .DW    (pmtr_pkg::WORD_W)
  ) u_rom (
    .clock      (clock),
    .wr_en      (prog_load_en),
    .wr_addr    (prog_load_addr),
    .wr_data    (prog_load_data),
    .rd_en      (rd_en),
    .rd_addr    (rd_addr),
    .rd_data_ff (rd_data)
  );

  // (RULE4) Sector check per variant
  assign req_legal = is_ext(tbl_req.op) ?
                     (tbl_req.sector != pmtr_pkg::SECTOR0) :
                     (tbl_req.sector == pmtr_pkg::SECTOR0);
  assign tbl_start = tbl_req.valid && (st_ff == pmtr_st_idle) && req_legal;

  // Table reads steal the read port, so fetch waits one cycle then.
  always_comb
  begin
    rd_en = 1'b1;
    if (st_ff == pmtr_st_wait)
    begin
      // (RULE3) Pointer concatenation
      // (RULE10) Both pointers used
      // (RULE11) Last page variant
      // (RULE16) Page and offset split
      // (RULE17) Excess high bits dropped
      rd_addr = tbl_addr(req_ff.op, tbhp_ff, tblp_ff);
    end
    else
    begin
      rd_addr = fetch_addr_ff;
    end
  end

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_req     = req_ff;
    nxt_busy    = tbl_busy_ff;
    nxt_illegal = 1'b0;
    nxt_wr      = '0;
    nxt_tblp    = tbl_busy_ff ? tblp_ff : (tblp_wr ? sfr_wdata : tblp_ff);
    nxt_tbhp    = tbl_busy_ff ? tbhp_ff : (tbhp_wr ? sfr_wdata : tbhp_ff);
    // (RULE9) Software latch write
    nxt_latch   = latch_wr ? sfr_wdata : table_high_byte_latch_ff;
    unique case (st_ff)
      pmtr_st_idle:
      begin
        nxt_illegal = tbl_req.valid && !req_legal;
        if (tbl_start)
        begin
          nxt_req  = tbl_req;
          nxt_st   = pmtr_st_wait;
          nxt_busy = 1'b1;
        end
      end
      pmtr_st_wait:
      begin
        nxt_st = pmtr_st_done;
      end
      pmtr_st_done:
      begin
        // (RULE8) Second cycle ends it
        nxt_st        = pmtr_st_idle;
        nxt_busy      = 1'b0;
        // (RULE5) Low byte to data
        nxt_wr.valid  = 1'b1;
        nxt_wr.sector = req_ff.sector;
        nxt_wr.dst    = req_ff.dst;
        nxt_wr.data   = rd_data[7:0];
        // (RULE6) High byte to latch
        // (RULE7) Unbacked bits zero
        nxt_latch     = rd_data[pmtr_pkg::WORD_W-1:8];
      end
    endcase
  end

  // (RULE2) Fetch starts at zero
  always_comb
  begin
    nxt_fetch  = fetch_addr_ff;
    if (fetch_load)
    begin
      nxt_fetch = fetch_target;
    end
    else if (fetch_adv && st_ff != pmtr_st_wait)
    begin
      nxt_fetch  = fetch_addr_ff + 1'b1;
    end
    nxt_fvalid = fetch_pend_ff;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_ff                    <= pmtr_st_idle;
      req_ff                   <= '0;
      tbl_busy_ff              <= 1'b0;
      tbl_illegal_ff           <= 1'b0;
      tbl_wr_ff                <= '0;
      tblp_ff                  <= pmtr_pkg::PTR_RST;
      tbhp_ff                  <= pmtr_pkg::PTR_RST;
      table_high_byte_latch_ff <= pmtr_pkg::LATCH_RST;
      fetch_addr_ff            <= pmtr_pkg::RESET_VEC;
      fetch_pend_ff            <= 1'b0;
      fetch_valid_ff           <= 1'b0;
      fetch_word_ff            <= 16'h0000;
    end
    else
    begin
      st_ff                    <= nxt_st;
      req_ff                   <= nxt_req;
      tbl_busy_ff              <= nxt_busy;
      tbl_illegal_ff           <= nxt_illegal;
      tbl_wr_ff                <= nxt_wr;
      tblp_ff                  <= nxt_tblp;
      tbhp_ff                  <= nxt_tbhp;
      table_high_byte_latch_ff <= nxt_latch;
      fetch_addr_ff            <= nxt_fetch;
      fetch_pend_ff            <= (st_ff != pmtr_st_wait);
      fetch_valid_ff           <= nxt_fvalid;
      fetch_word_ff            <= fetch_pend_ff ? rd_data : fetch_word_ff;
    end
  end

  // (RULE13) Programming data pin
  // (RULE14) Shared functions gated
  // (RULE15) Data two-way, clock input
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      debug_serial_data_pin_o_ff   <= 1'b0;
      debug_serial_data_pin_oe_ff  <= 1'b0;
      debug_serial_clock_pin_o_ff  <= 1'b0;
      debug_serial_clock_pin_oe_ff <= 1'b0;
      gpio_data_in_ff              <= 1'b0;
      gpio_clk_in_ff               <= 1'b0;
      link_data_in_ff              <= 1'b0;
      link_clk_in_ff               <= 1'b0;
    end
    else
    begin
      debug_serial_data_pin_o_ff   <= debug_en ? dbg_data_out : gpio_data_out;
      debug_serial_data_pin_oe_ff  <= debug_en ? dbg_data_oe : gpio_data_oe;
      debug_serial_clock_pin_o_ff  <= debug_en ? 1'b0 : gpio_clk_out;
      debug_serial_clock_pin_oe_ff <= debug_en ? 1'b0 : gpio_clk_oe;
      gpio_data_in_ff              <= debug_en ? 1'b0 : debug_serial_data_pin_i;
      gpio_clk_in_ff               <= debug_en ? 1'b0 : debug_serial_clock_pin_i;
      link_data_in_ff              <= debug_serial_data_pin_i;
      link_clk_in_ff               <= debug_serial_clock_pin_i;
    end
  end

  // (RULE8) Two-cycle completion
  sequence seq_tbl_finish;
    ##1 nxt_wr.valid ##1 tbl_wr_ff.valid;
  endsequence
  chk_table_two_cycle: assert property ( // (RULE8)
    tbl_start |=> seq_tbl_finish)
    else $error("table read did not finish in two cycles");

  // (RULE6) Latch follows word
  chk_latch_load: assert property ( // (RULE6)
    (st_ff == pmtr_st_done) |=>
    table_high_byte_latch_ff == $past(rd_data[15:8]))
    else $error("latch missed the high byte");

  // (RULE5) Low byte delivered
  chk_low_byte: assert property ( // (RULE5)
    (st_ff == pmtr_st_done) |=> tbl_wr_ff.data == $past(rd_data[7:0]))
    else $error("low byte wrong");

  // (RULE11) Last page address
  chk_last_page: assert property ( // (RULE11)
    (st_ff == pmtr_st_wait && req_ff.op == pmtr_pkg::pmtr_op_rdl) |->
    rd_addr == {6'h3f, tblp_ff})
    else $error("last page read used wrong page");

  // (RULE3) Full pointer address
  chk_full_addr: assert property ( // (RULE3)
    (st_ff == pmtr_st_wait && req_ff.op == pmtr_pkg::pmtr_op_rd) |->
    rd_addr == {tbhp_ff[5:0], tblp_ff})
    else $error("table address not formed from both pointers");

  // (RULE4) Wrong sector refused
  chk_sector: assert property ( // (RULE4)
    (st_ff == pmtr_st_idle && tbl_req.valid && !req_legal) |=>
    tbl_illegal_ff && st_ff == pmtr_st_idle)
    else $error("wrong sector request accepted");

  // (RULE2) Reset vector
  chk_reset_vec: assert property ( // (RULE2)
    @(posedge clock) disable iff (1'b0)
    !rst_n |=> fetch_addr_ff == pmtr_pkg::RESET_VEC)
    else $error("fetch did not restart at zero");

  // (RULE14) Debug owns pins
  chk_debug_gate: assert property ( // (RULE14)
    debug_en |=> !gpio_data_in_ff && !debug_serial_clock_pin_oe_ff)
    else $error("shared function active during debug");

endmodule

/* File: include/pmtr_pkg.sv */
// Package of constants and carriers for the program memory table read block.
package pmtr_pkg;

  localparam int unsigned WORDS      = 16384;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned ADDR_W     = 14;
  localparam int unsigned PAGE_W     = 8;
  localparam int unsigned HI_PTR_W   = ADDR_W - PAGE_W;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned SECT_W     = 2;
  localparam logic [13:0] RESET_VEC  = 14'h0000;
  localparam logic [5:0]  LAST_PAGE  = 6'h3f;
  localparam logic [1:0]  SECTOR0    = 2'h0;
  localparam logic [7:0]  LATCH_RST  = 8'h00;
  localparam logic [7:0]  PTR_RST    = 8'h00;
  localparam int unsigned TBL_CYCLES = 2;

  typedef enum logic [1:0] {
    pmtr_op_rd,
    pmtr_op_rdl,
    pmtr_op_ext_rd,
    pmtr_op_ext_rdl
  } pmtr_op_t;

  typedef struct packed {
    logic           valid;
    pmtr_op_t       op;
    logic [1:0]     sector;
    logic [7:0]     dst;
  } pmtr_req_t;

  typedef struct packed {
    logic           valid;
    logic [1:0]     sector;
    logic [7:0]     dst;
    logic [7:0]     data;
  } pmtr_wr_t;

endpackage

/* File: hw/pmtr_rom.sv */
// Program word memory with a registered read port and a load port.
`timescale 1ns/100ps
module pmtr_rom #(
  parameter int unsigned DEPTH = 16384,
  parameter int unsigned AW    = 14,
  parameter int unsigned DW    = 16
) (
  // Clock.
  input  wire logic          clock,
  // Load port.
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read port.
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data_ff
);

  initial
  begin
    if (DEPTH != (1 << AW))
    begin
      $error("pmtr_rom depth must equal two to the address width");
    end
  end

  logic [DW-1:0] mem [DEPTH];

  // Read data leave through a register so the core sees a stable word.
  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en)
    begin
      rd_data_ff <= mem[rd_addr];
    end
  end

endmodule

/* File: dv/pmtr_core_model.sv */
// Core model that issues table read requests toward the block.
`timescale 1ns/100ps
module pmtr_core_model (
  // Clock.
  input  wire logic           clock,
  // Request.
  output pmtr_pkg::pmtr_req_t tbl_req
);
  initial tbl_req = '0;

  // One read at a time.
  // Reads are never nested, so the latch is not overwritten mid-use.
  task automatic issue(input pmtr_pkg::pmtr_op_t op, input logic [1:0] sec,
                       input logic [7:0] dst);
    begin
      tbl_req = '{1'b1, op, sec, dst};
      @(posedge clock);
      #2;
      tbl_req = '0;
    end
  endtask
endmodule

/* File: dv/tb_pmtr_top.sv */
// Self-checking testbench for the program memory table read block.
`timescale 1ns/100ps
module tb_pmtr_top;
  logic                clock = 1'b0;
  logic                rst_n = 1'b0;
  logic                fetch_adv = 1'b0;
  logic                fetch_load = 1'b0;
  logic [13:0]         fetch_target = 14'h0000;
  logic [13:0]         fetch_addr_ff;
  logic [15:0]         fetch_word_ff;
  logic                fetch_valid_ff;
  logic                tblp_wr = 1'b0;
  logic                tbhp_wr = 1'b0;
  logic                latch_wr = 1'b0;
  logic [7:0]          sfr_wdata = 8'h00;
  logic [7:0]          tblp_ff;
  logic [7:0]          tbhp_ff;
  logic [7:0]          table_high_byte_latch_ff;
  pmtr_pkg::pmtr_req_t tbl_req;
  logic                tbl_busy_ff;
  logic                tbl_illegal_ff;
  pmtr_pkg::pmtr_wr_t  tbl_wr_ff;
  logic                prog_load_en = 1'b0;
  logic [13:0]         prog_load_addr = 14'h0000;
  logic [15:0]         prog_load_data = 16'h0000;
  logic                debug_en = 1'b0;
  logic                dbg_data_out = 1'b0;
  logic                dbg_data_oe = 1'b0;
  logic                gpio_data_out = 1'b0;
  logic                gpio_data_oe = 1'b0;
  logic                gpio_clk_out = 1'b0;
  logic                gpio_clk_oe = 1'b0;
  logic                data_o, data_oe, clk_o, clk_oe;
  logic                gpio_data_in_ff, gpio_clk_in_ff;
  logic                link_data_in_ff, link_clk_in_ff;
  logic                ext_data = 1'b1;
  logic                ext_clk = 1'b1;
  wire                 data_pin = data_oe ? data_o : ext_data;
  wire                 clk_pin = clk_oe ? clk_o : ext_clk;
  int                  bad_count = 0;
  int                  checked = 0;

  pmtr_core_model core (.clock(clock), .tbl_req(tbl_req));

  pmtr_top DUT (
    .clock(clock), .rst_n(rst_n), .fetch_adv(fetch_adv),
    .fetch_load(fetch_load), .fetch_target(fetch_target),
    .fetch_addr_ff(fetch_addr_ff), .fetch_word_ff(fetch_word_ff),
    .fetch_valid_ff(fetch_valid_ff), .tblp_wr(tblp_wr), .tbhp_wr(tbhp_wr),
    .latch_wr(latch_wr), .sfr_wdata(sfr_wdata), .tblp_ff(tblp_ff),
    .tbhp_ff(tbhp_ff), .table_high_byte_latch_ff(table_high_byte_latch_ff),
    .tbl_req(tbl_req), .tbl_busy_ff(tbl_busy_ff),
    .tbl_illegal_ff(tbl_illegal_ff), .tbl_wr_ff(tbl_wr_ff),
    .prog_load_en(prog_load_en), .prog_load_addr(prog_load_addr),
    .prog_load_data(prog_load_data), .debug_en(debug_en),
    .debug_serial_data_pin_i(data_pin), .debug_serial_clock_pin_i(clk_pin),
    .dbg_data_out(dbg_data_out), .dbg_data_oe(dbg_data_oe),
    .gpio_data_out(gpio_data_out), .gpio_data_oe(gpio_data_oe),
    .gpio_clk_out(gpio_clk_out), .gpio_clk_oe(gpio_clk_oe),
    .debug_serial_data_pin_o_ff(data_o),
    .debug_serial_data_pin_oe_ff(data_oe),
    .debug_serial_clock_pin_o_ff(clk_o),
    .debug_serial_clock_pin_oe_ff(clk_oe),
    .gpio_data_in_ff(gpio_data_in_ff), .gpio_clk_in_ff(gpio_clk_in_ff),
    .link_data_in_ff(link_data_in_ff), .link_clk_in_ff(link_clk_in_ff)
  );

  initial
  begin
    forever #12.5 clock = ~clock;
  end

  // Every stored word is a function of its address, so any read is known.
  function automatic logic [15:0] wexp(input logic [13:0] a);
    wexp = {a[7:0] ^ 8'ha5, a[13:6]};
  endfunction

  task automatic step();
    begin
      @(posedge clock);
      #2;
    end
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    begin
      checked++;
      if (got !== exp)
      begin
        bad_count++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task automatic summarize();
    begin
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  task automatic set_ptr(input logic [7:0] hi, input logic [7:0] lo);
    begin
      sfr_wdata = hi;
      tbhp_wr = 1'b1;
      step();
      tbhp_wr = 1'b0;
      tblp_wr = 1'b1;
      sfr_wdata = lo;
      step();
      tblp_wr = 1'b0;
      check({tbhp_ff, tblp_ff}, {hi, lo});
    end
  endtask

  // Issues one read and judges timing, data, latch, destination and sector.
  task automatic do_rd(input pmtr_pkg::pmtr_op_t op, input logic [1:0] sec,
                       input logic [13:0] a);
    int n;
    int busy_n;
    logic [15:0] want;
    begin
      core.issue(op, sec, a[7:0] ^ 8'h3c);
      n = 0;
      busy_n = (tbl_busy_ff === 1'b1) ? 1 : 0;
      while (n < 6 && tbl_wr_ff.valid !== 1'b1)
      begin
        step();
        n++;
        if (tbl_busy_ff === 1'b1)
          busy_n++;
      end
      if (n == 6)
      begin
        bad_count++;
        summarize();
      end
      check(n[15:0], 16'h0002);
      check(busy_n[15:0], 16'h0002);
      check({15'h0000, fetch_valid_ff}, 16'h0000);
      check({table_high_byte_latch_ff, tbl_wr_ff.data}, wexp(a));
      want = {6'h00, sec, a[7:0] ^ 8'h3c};
      check({6'h00, tbl_wr_ff.sector, tbl_wr_ff.dst}, want);
    end
  endtask

  task automatic t_fetch();
    begin
      check({2'h0, fetch_addr_ff}, 16'h0000);
      check(fetch_word_ff, wexp(14'h0000));
      fetch_adv = 1'b1;
      repeat (3) step();
      fetch_adv = 1'b0;
      check({2'h0, fetch_addr_ff}, 16'h0003);
      fetch_target = 14'h3f00;
      fetch_load = 1'b1;
      fetch_adv = 1'b1;
      step();
      fetch_load = 1'b0;
      fetch_adv = 1'b0;
      check({2'h0, fetch_addr_ff}, 16'h3f00);
      repeat (2) step();
      check(fetch_word_ff, wexp(14'h3f00));
      check({15'h0000, fetch_valid_ff}, 16'h0001);
      $display("test fetch done");
    end
  endtask

  task automatic t_table();
    begin
      set_ptr(8'h3f, 8'h06);
      do_rd(pmtr_pkg::pmtr_op_rd, 2'h0, 14'h3f06);
      set_ptr(8'h3f, 8'h05);
      // Back-to-back: the next read goes in one cycle after busy falls.
      do_rd(pmtr_pkg::pmtr_op_rd, 2'h0, 14'h3f05);
      do_rd(pmtr_pkg::pmtr_op_ext_rd, 2'h2, 14'h3f05);
      set_ptr(8'hd2, 8'h34);
      do_rd(pmtr_pkg::pmtr_op_rd, 2'h0, 14'h1234);
      do_rd(pmtr_pkg::pmtr_op_rdl, 2'h0, 14'h3f34);
      do_rd(pmtr_pkg::pmtr_op_ext_rdl, 2'h3, 14'h3f34);
      do_rd(pmtr_pkg::pmtr_op_ext_rd, 2'h1, 14'h1234);
      $display("test table done");
    end
  endtask

  task automatic t_illegal();
    logic ill;
    logic wr;
    begin
      for (int k = 0; k < 2; k++)
      begin
        core.issue(k == 0 ? pmtr_pkg::pmtr_op_rd : pmtr_pkg::pmtr_op_ext_rd,
                   k == 0 ? 2'h1 : 2'h0, 8'h11);
        ill = tbl_illegal_ff;
        wr = 1'b0;
        repeat (4)
        begin
          step();
          ill = ill | tbl_illegal_ff;
          wr = wr | tbl_wr_ff.valid;
        end
        check({14'h0, ill, wr}, 16'h0002);
      end
      sfr_wdata = 8'h9c;
      latch_wr = 1'b1;
      step();
      latch_wr = 1'b0;
      check({8'h00, table_high_byte_latch_ff}, 16'h009c);
      $display("test illegal and latch done");
    end
  endtask

  task automatic t_pins();
    begin
      gpio_data_oe = 1'b1;
      gpio_data_out = 1'b1;
      gpio_clk_oe = 1'b1;
      dbg_data_oe = 1'b1;
      repeat (2) step();
      check({12'h0, data_o, data_oe, clk_o, clk_oe}, 16'h000d);
      check({14'h0, gpio_data_in_ff, link_data_in_ff}, 16'h0003);
      debug_en = 1'b1;
      ext_data = 1'b0;
      repeat (2) step();
      check({12'h0, data_o, data_oe, clk_oe, gpio_data_in_ff}, 16'h0004);
      check({14'h0, gpio_clk_in_ff, link_clk_in_ff}, 16'h0001);
      dbg_data_oe = 1'b0;
      ext_data = 1'b1;
      repeat (2) step();
      check({14'h0, data_oe, link_data_in_ff}, 16'h0001);
      $display("test pins done");
    end
  endtask

  initial
  begin
    repeat (10) @(posedge clock);
    #2;
    rst_n = 1'b1;
    prog_load_en = 1'b1;
    for (int i = 0; i < 16384; i++)
    begin
      prog_load_addr = i[13:0];
      prog_load_data = wexp(i[13:0]);
      step();
    end
    prog_load_en = 1'b0;
    t_fetch();
    t_table();
    t_illegal();
    t_pins();
    summarize();
  end
endmodule
